//--- verilog/gis_status_pin.sv
// live event status register and multi-function pin control
`timescale 1ns/1ps
`include "gis_cfg.svh"
// Summary of operation
// - status bits 7,6,5 show live short circuit on left, right, common drivers.
// - button bit 3 sets on press, stays until register 14 is read.
// - bit 2 reads 1 while a headset is present.
// - bits 1,0 read 1 while left/right record power is below noise threshold.
// - bit 4 reserved, reads 0; software never writes it.
// - function field resets to 0000 (pin off); 0001 carries record word clock.
// - codes 0010..0101 output selected clock divided by 1, 2, 4, 8.
// - 0110 outputs short-circuit interrupt, 0111 noise-gate interrupt.
// - 1000 makes pin general input, 1001 general output.
// - 1011 makes pin the word clock, direction from audio interface setting.
// - 1100 outputs active-high button interrupt following debounced press.
// - 1101 headset interrupt; 1110 headset OR button interrupt.
// - 1111 ORs headset, button, short-circuit and noise-gate interrupts.
// - control bit 3 picks pin clock: 0 PLL, 1 divider mux; resets 0.
// - with bit 2 at 0 each interrupt is one 2ms high pulse.
// - with bit 2 at 1 pulses repeat until sticky register 96 is read.
// - in input mode a read-only bit returns the pin level.
// - in output mode pin drives a writable bit, reset 0.
module gis_status_pin
  import gis_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  input  wire gis_bus_type    bus,
  output logic [7:0]          rdata,
  input  wire gis_events_type events,
  input  wire logic           pll_clk_en,
  input  wire logic           div_clk_en,
  input  wire logic           adc_wck,
  input  wire logic           wck_out,
  input  wire logic           wck_is_master,
  output logic                wck_in,
  input  wire logic           pin_in,
  output logic                pin_out,
  output logic                pin_oe_b
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_sync_next;
  logic       pin_lvl_reg;
  logic       pin_lvl_next;
  always_comb begin
    pin_sync_next = {pin_sync_reg[1:0], pin_in};
    pin_lvl_next  = pin_lvl_reg;
    if (pin_sync_reg[2] == pin_sync_reg[1]) begin
      pin_lvl_next = pin_sync_reg[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync_reg <= 3'h0;
      pin_lvl_reg  <= 1'b0;
    end else begin
      pin_sync_reg <= pin_sync_next;
      pin_lvl_reg  <= pin_lvl_next;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [3:0]   func_reg;
  logic [3:0]   func_next;
  logic         muxsel_reg;
  logic         muxsel_next;
  logic         cont_reg;
  logic         cont_next;
  logic         gpout_reg;
  logic         gpout_next;
  logic         btn_reg;
  logic         btn_next;
  logic [7:0]   rdata_next;
  logic [7:0]   status_live;
  gis_func_type fn;
  assign fn = gis_func_type'(func_reg);
  always_comb begin
    status_live = `GIS_RST_BYTE;
    status_live[`GIS_BIT_SC_L] = events.sc_left;
    status_live[`GIS_BIT_SC_R] = events.sc_right;
    status_live[`GIS_BIT_SC_C] = events.sc_common;
    status_live[`GIS_BIT_RSVD] = 1'b0;
    status_live[`GIS_BIT_BTN]  = btn_reg;
    status_live[`GIS_BIT_HS]   = events.headset;
    status_live[`GIS_BIT_NG_L] = events.ng_left;
    status_live[`GIS_BIT_NG_R] = events.ng_right;
  end

  always_comb begin
    func_next   = func_reg;
    muxsel_next = muxsel_reg;
    cont_next   = cont_reg;
    gpout_next  = gpout_reg;
    rdata_next  = `GIS_RST_BYTE;
    btn_next    = btn_reg;
    if (bus.rd && bus.addr == `GIS_OFS_BTN_CLEAR) begin
      btn_next = 1'b0;
    end
    // press sets, wins over the clearing read
    if (events.button) begin
      btn_next = 1'b1;
    end
    if (bus.wr && bus.addr == `GIS_OFS_PINCTL) begin
      func_next   = bus.wdata[`GIS_FUNC_MSB:`GIS_FUNC_LSB];
      muxsel_next = bus.wdata[`GIS_BIT_MUXSEL];
      cont_next   = bus.wdata[`GIS_BIT_CONT];
      gpout_next  = bus.wdata[`GIS_BIT_GPOUT];
    end
    if (bus.rd) begin
      case (bus.addr)
        `GIS_OFS_STATUS: begin
          rdata_next = status_live;
        end
        `GIS_OFS_PINCTL: begin
          rdata_next = {func_reg, muxsel_reg, cont_reg, 1'b0, gpout_reg};
          rdata_next[`GIS_BIT_GPIN] = pin_lvl_reg;
        end
        default: begin
          rdata_next = `GIS_RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      func_reg   <= `GIS_RST_FUNC;
      muxsel_reg <= 1'b0;
      cont_reg   <= 1'b0;
      gpout_reg  <= 1'b0;
      btn_reg    <= 1'b0;
      rdata      <= `GIS_RST_BYTE;
    end else begin
      func_reg   <= func_next;
      muxsel_reg <= muxsel_next;
      cont_reg   <= cont_next;
      gpout_reg  <= gpout_next;
      btn_reg    <= btn_next;
      rdata      <= rdata_next;
    end
  end

  // ****************************************
  // clock divider
  // ****************************************
  // each enable is one source edge; bit n toggles every 2^n edges
  logic       src_en;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  assign src_en = muxsel_reg ? div_clk_en : pll_clk_en;
  always_comb begin
    div_next = div_reg;
    // free-running counter, each bit 50% duty
    if (src_en) begin
      div_next = div_reg + 4'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_next;
    end
  end
  // ****************************************
  // interrupt pulse shaper
  // ****************************************
  localparam logic [`GIS_CNT_W-1:0] PULSE_CYC = `GIS_CNT_W'(`GIS_PULSE_CYC);
  logic                 irq_src;
  logic                 irq_src_reg;
  logic                 sticky_rd;
  logic                 cont_hold_reg;
  logic                 cont_hold_next;
  logic [`GIS_CNT_W-1:0] pcnt_reg;
  logic [`GIS_CNT_W-1:0] pcnt_next;
  gis_pulse_state_type  ps_reg;
  gis_pulse_state_type  ps_next;
  logic                 irq_rise;
  always_comb begin
    case (fn)
      GIS_FN_SC_IRQ:  irq_src = events.sc_left | events.sc_right | events.sc_common;
      GIS_FN_NG_IRQ:  irq_src = events.ng_left | events.ng_right;
      GIS_FN_BTN_IRQ: irq_src = events.button;
      GIS_FN_HS_IRQ:  irq_src = events.headset;
      GIS_FN_HB_IRQ:  irq_src = events.headset | events.button;
      GIS_FN_ALL_IRQ: irq_src = events.headset | events.button | events.sc_left
                                | events.sc_right | events.sc_common
                                | events.ng_left | events.ng_right;
      default:        irq_src = 1'b0;
    endcase
  end
  assign irq_rise  = irq_src & ~irq_src_reg;
  assign sticky_rd = bus.rd && bus.addr == `GIS_OFS_STICKY;
  always_comb begin
    ps_next        = ps_reg;
    pcnt_next      = pcnt_reg;
    cont_hold_next = cont_hold_reg;
    // repeat until sticky flags read; a new event re-arms
    if (sticky_rd) begin
      cont_hold_next = 1'b0;
    end
    if (irq_rise) begin
      cont_hold_next = cont_reg;
    end
    case (ps_reg)
      GIS_PS_IDLE: begin
        if (irq_rise) begin
          ps_next   = GIS_PS_HIGH;
          pcnt_next = PULSE_CYC - `GIS_CNT_W'(1);
        end
      end
      GIS_PS_HIGH: begin
        if (pcnt_reg == '0) begin
          ps_next   = cont_hold_next ? GIS_PS_GAP : GIS_PS_IDLE;
          pcnt_next = `GIS_GAP_CYC - `GIS_CNT_W'(1);
        end else begin
          pcnt_next = pcnt_reg - `GIS_CNT_W'(1);
        end
      end
      GIS_PS_GAP: begin
        if (!cont_hold_next) begin
          ps_next = GIS_PS_IDLE;
        end else if (pcnt_reg == '0) begin
          ps_next   = GIS_PS_HIGH;
          pcnt_next = PULSE_CYC - `GIS_CNT_W'(1);
        end else begin
          pcnt_next = pcnt_reg - `GIS_CNT_W'(1);
        end
      end
      default: begin
        ps_next = GIS_PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ps_reg        <= GIS_PS_IDLE;
      pcnt_reg      <= '0;
      cont_hold_reg <= 1'b0;
      irq_src_reg   <= 1'b0;
    end else begin
      ps_reg        <= ps_next;
      pcnt_reg      <= pcnt_next;
      cont_hold_reg <= cont_hold_next;
      irq_src_reg   <= irq_src;
    end
  end

  // ****************************************
  // pin output mux
  // ****************************************
  logic pin_out_next;
  logic pin_oe_b_next;
  logic wck_in_next;
  always_comb begin
    pin_out_next  = 1'b0;
    pin_oe_b_next = 1'b0;
    wck_in_next   = 1'b0;
    case (fn)
      GIS_FN_ADC_WCK: pin_out_next = adc_wck;
      GIS_FN_DIV1:    pin_out_next = div_reg[0];
      GIS_FN_DIV2:    pin_out_next = div_reg[1];
      GIS_FN_DIV4:    pin_out_next = div_reg[2];
      GIS_FN_DIV8:    pin_out_next = div_reg[3];
      GIS_FN_SC_IRQ, GIS_FN_NG_IRQ, GIS_FN_BTN_IRQ,
      GIS_FN_HS_IRQ, GIS_FN_HB_IRQ, GIS_FN_ALL_IRQ: begin
        pin_out_next = ps_reg == GIS_PS_HIGH;
      end
      GIS_FN_GP_IN:   pin_oe_b_next = 1'b1;
      GIS_FN_GP_OUT:  pin_out_next = gpout_reg;
      // word clock direction from interface setting
      GIS_FN_WCK: begin
        pin_out_next  = wck_out;
        pin_oe_b_next = ~wck_is_master;
        wck_in_next   = pin_lvl_reg;
      end
      // off and reserved codes leave the pin released
      default:        pin_oe_b_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_out  <= 1'b0;
      pin_oe_b <= 1'b1;
      wck_in   <= 1'b0;
    end else begin
      pin_out  <= pin_out_next;
      pin_oe_b <= pin_oe_b_next;
      wck_in   <= wck_in_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_status_shorts: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus.rd && bus.addr == `GIS_OFS_STATUS |=> rdata[7:5] ==
      $past({events.sc_left, events.sc_right, events.sc_common}))
    else $error("short bits wrong");
  a_button_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    btn_reg && !(bus.rd && bus.addr == `GIS_OFS_BTN_CLEAR) |=> btn_reg)
    else $error("button bit lost");
  a_status_live: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus.rd && bus.addr == `GIS_OFS_STATUS |=> rdata[2:0] ==
      $past({events.headset, events.ng_left, events.ng_right}))
    else $error("headset or gate bits wrong");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(bus.rd && bus.addr == `GIS_OFS_STATUS) |-> !rdata[4])
    else $error("reserved bit set");
  a_gpout_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fn == GIS_FN_GP_OUT && $stable(fn) |=> pin_out == $past(gpout_reg) && !pin_oe_b)
    else $error("gp output wrong");
  a_gpin_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fn == GIS_FN_GP_IN |=> pin_oe_b)
    else $error("gp input driven");
  a_pulse_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ps_reg == GIS_PS_IDLE && irq_rise |=> ps_reg == GIS_PS_HIGH [*8])
    else $error("pulse too short");
  a_pulse_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ps_reg == GIS_PS_HIGH && pcnt_reg == '0 && !cont_hold_next |=> ps_reg == GIS_PS_IDLE)
    else $error("single pulse did not end");
  a_cont_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ps_reg == GIS_PS_GAP && sticky_rd && !irq_rise |=> ps_reg == GIS_PS_IDLE)
    else $error("pulses not stopped");
  a_cont_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sticky_rd && !irq_rise |=> !cont_hold_reg) else $error("continuous mode not cleared");
  a_reserved_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fn == GIS_FN_RSVD |=> pin_oe_b)
    else $error("reserved code drives pin");

  c_single_pulse: cover property (@(posedge clk_sys) disable iff (!rst_b)
    ps_reg == GIS_PS_HIGH && pcnt_reg == '0 && !cont_reg);
  c_repeat_pulse: cover property (@(posedge clk_sys) disable iff (!rst_b)
    ps_reg == GIS_PS_GAP ##1 ps_reg == GIS_PS_HIGH);
  c_button_clear: cover property (@(posedge clk_sys) disable iff (!rst_b)
    btn_reg ##1 !btn_reg);
  c_div8: cover property (@(posedge clk_sys) disable iff (!rst_b)
    fn == GIS_FN_DIV8 && div_reg == 4'hf);

endmodule : gis_status_pin

//--- verilog/gis_cfg.svh
// constants for the event status and multi-function pin block
`ifndef GIS_CFG_SVH
`define GIS_CFG_SVH
`define GIS_OFS_STATUS      8'h61
`define GIS_OFS_PINCTL      8'h62
`define GIS_OFS_BTN_CLEAR   8'h0e
`define GIS_OFS_STICKY      8'h60
`define GIS_RST_BYTE        8'h00
`define GIS_RST_FUNC        4'h0
`define GIS_PULSE_NS        2000000
`define GIS_CLK_NS          40
`define GIS_PULSE_CYC       (`GIS_PULSE_NS / `GIS_CLK_NS)
`define GIS_CNT_W           16
`define GIS_GAP_CYC         16'h0100
`define GIS_BIT_SC_L        7
`define GIS_BIT_SC_R        6
`define GIS_BIT_SC_C        5
`define GIS_BIT_RSVD        4
`define GIS_BIT_BTN         3
`define GIS_BIT_HS          2
`define GIS_BIT_NG_L        1
`define GIS_BIT_NG_R        0
`define GIS_BIT_MUXSEL      3
`define GIS_BIT_CONT        2
`define GIS_BIT_GPIN        1
`define GIS_BIT_GPOUT       0
`define GIS_FUNC_MSB        7
`define GIS_FUNC_LSB        4
`endif

//--- verilog/gis_pkg.sv
// types for the event status and multi-function pin block
package gis_pkg;
  typedef enum logic [3:0] {
    GIS_FN_OFF     = 4'b0000,
    GIS_FN_ADC_WCK = 4'b0001,
    GIS_FN_DIV1    = 4'b0010,
    GIS_FN_DIV2    = 4'b0011,
    GIS_FN_DIV4    = 4'b0100,
    GIS_FN_DIV8    = 4'b0101,
    GIS_FN_SC_IRQ  = 4'b0110,
    GIS_FN_NG_IRQ  = 4'b0111,
    GIS_FN_GP_IN   = 4'b1000,
    GIS_FN_GP_OUT  = 4'b1001,
    GIS_FN_RSVD    = 4'b1010,
    GIS_FN_WCK     = 4'b1011,
    GIS_FN_BTN_IRQ = 4'b1100,
    GIS_FN_HS_IRQ  = 4'b1101,
    GIS_FN_HB_IRQ  = 4'b1110,
    GIS_FN_ALL_IRQ = 4'b1111
  } gis_func_type;

  typedef enum logic [1:0] {
    GIS_PS_IDLE = 2'b00,
    GIS_PS_HIGH = 2'b01,
    GIS_PS_GAP  = 2'b10
  } gis_pulse_state_type;

  typedef struct packed {
    logic sc_left;
    logic sc_right;
    logic sc_common;
    logic button;
    logic headset;
    logic ng_left;
    logic ng_right;
  } gis_events_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gis_bus_type;
endpackage : gis_pkg

//--- verification/gis_host_model.sv
// host processor model on the far side of the multi-function pin
`timescale 1ns/1ps
module gis_host_model (
  input  wire logic clk_sys,
  input  wire logic pin_out,
  input  wire logic pin_oe_b,
  input  wire logic host_en,
  input  wire logic host_val,
  output logic      pin_lvl,
  output int        rise_cnt
);
  bit   prev;
  // weak pull-down: a pin nobody drives settles low, never holds old value
  assign pin_lvl = !pin_oe_b ? pin_out : (host_en ? host_val : 1'b0);
  always @(posedge clk_sys) begin
    if (pin_lvl && !prev) rise_cnt++;
    prev = pin_lvl;
  end
endmodule : gis_host_model

//--- verification/gis_status_pin_test.sv
// self-checking bench for the event status and multi-function pin block
`timescale 1ns/1ps
`include "gis_cfg.svh"
module gis_status_pin_test
  import gis_pkg::*;
;
  logic           clk_sys;
  logic           rst_b;
  gis_bus_type    bus;
  logic [7:0]     rdata;
  gis_events_type ev;
  logic           pll_en, div_en, adc_wck, wck_out, wck_master, wck_in;
  logic           pin_in, pin_out, pin_oe_b, host_en, host_val;
  int             rise_cnt, err_total, tests_run, cyc, i, k, s, n;
  integer         seed;
  logic           btn_m, prev;
  logic [7:0]     d;
  logic [3:0]     codes [6] = '{4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
  logic [3:0]     masks [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'hf};
  logic [6:0]     srcs  [4] = '{7'h40, 7'h02, 7'h08, 7'h04};

  gis_status_pin dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .events(ev), .pll_clk_en(pll_en), .div_clk_en(div_en), .adc_wck(adc_wck),
    .wck_out(wck_out), .wck_is_master(wck_master), .wck_in(wck_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b));
  gis_host_model u_host (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .host_en(host_en), .host_val(host_val), .pin_lvl(pin_in), .rise_cnt(rise_cnt));

  // ****************************************
  // clock, enables and reference model
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // pll source every 2nd cycle, divider source every 4th: ratios differ
  always @(negedge clk_sys) begin
    cyc++;
    pll_en = cyc[0];
    div_en = (cyc[1:0] == 2'b00);
  end
  // sticky button, cleared by its read
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) btn_m = 1'b0;
    else if (ev.button) btn_m = 1'b1;
    else if (bus.rd && bus.addr == `GIS_OFS_BTN_CLEAR) btn_m = 1'b0;
  end
  function automatic logic [7:0] stat_exp();
    return {ev.sc_left, ev.sc_right, ev.sc_common, 1'b0, btn_m, ev.headset,
            ev.ng_left, ev.ng_right};
  endfunction : stat_exp

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    bus = '{1'b1, 1'b0, a, v};
    @(negedge clk_sys);
    bus = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    bus = '0;
    v = rdata;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(32'(v), 32'(exp));
  endtask : rdchk
  task automatic do_reset();
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
  endtask : do_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // pulse plus gap plus a few short tests stay well under this span
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_total++;
    $display("watchdog expired at %0t", $time);
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h811c_3c70;
    err_total = 0;
    tests_run = 0;
    bus = '0;
    ev = '0;
    {adc_wck, wck_out, wck_master, host_en, host_val} = '0;
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    rdchk(`GIS_OFS_STATUS, 8'h00);
    rdchk(`GIS_OFS_PINCTL, 8'h00);
    rdchk(8'h63, 8'h00);
    chk(32'(pin_oe_b), 32'h1);
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      ev = 7'($random(seed));
      repeat (3) @(negedge clk_sys);
      rdchk(`GIS_OFS_STATUS, stat_exp());
    end
    ev = 7'h08;
    repeat (3) @(negedge clk_sys);
    ev = '0;
    repeat (3) @(negedge clk_sys);
    rdchk(`GIS_OFS_STATUS, 8'h08);
    rd(`GIS_OFS_BTN_CLEAR, d);
    rdchk(`GIS_OFS_STATUS, 8'h00);
    $display("status test done");
    wr(`GIS_OFS_PINCTL, 8'h91);
    repeat (2) @(negedge clk_sys);
    chk(32'({pin_oe_b, pin_out}), 32'h1);
    wr(`GIS_OFS_PINCTL, 8'h92);
    // pin level needs the three-stage sync before it reads back
    repeat (6) @(negedge clk_sys);
    rdchk(`GIS_OFS_PINCTL, 8'h90);
    wr(`GIS_OFS_PINCTL, 8'h80);
    host_en = 1'b1;
    for (i = 0; i < 2; i++) begin
      host_val = i[0];
      repeat (6) @(negedge clk_sys);
      rdchk(`GIS_OFS_PINCTL, {6'h20, i[0], 1'b0});
    end
    for (i = 0; i < 2; i++) begin
      wr(`GIS_OFS_PINCTL, i ? 8'ha0 : 8'h00);
      repeat (2) @(negedge clk_sys);
      chk(32'(pin_oe_b), 32'h1);
    end
    $display("general pin test done");
    wr(`GIS_OFS_PINCTL, 8'h10);
    for (i = 0; i < 8; i++) begin
      adc_wck = 1'($random(seed));
      @(negedge clk_sys);
      chk(32'({pin_oe_b, pin_out}), 32'(adc_wck));
    end
    wck_master = 1'b1;
    wr(`GIS_OFS_PINCTL, 8'hb0);
    for (i = 0; i < 8; i++) begin
      wck_out = 1'($random(seed));
      @(negedge clk_sys);
      chk(32'({pin_oe_b, pin_out}), 32'(wck_out));
    end
    wck_master = 1'b0;
    for (i = 0; i < 4; i++) begin
      host_val = 1'($random(seed));
      repeat (6) @(negedge clk_sys);
      chk(32'({pin_oe_b, wck_in}), 32'({1'b1, host_val}));
    end
    host_en = 1'b0;
    $display("word clock test done");
    for (s = 0; s < 2; s++) begin
      for (k = 0; k < 4; k++) begin
        wr(`GIS_OFS_PINCTL, 8'(((2 + k) << 4) | (s << 3)));
        repeat (20) @(negedge clk_sys);
        n = 0;
        prev = pin_out;
        repeat (128) begin
          @(negedge clk_sys);
          if (pin_out !== prev) n++;
          prev = pin_out;
        end
        chk(32'(n), 32'((s ? 32 : 64) >> k));
      end
    end
    $display("clock test done");
    for (i = 0; i < 6; i++) begin
      for (s = 0; s < 4; s++) begin
        do_reset();
        wr(`GIS_OFS_PINCTL, {codes[i], 4'h0});
        repeat (3) @(negedge clk_sys);
        chk(32'({pin_oe_b, pin_out}), 32'h0);
        ev = srcs[s];
        repeat (6) @(negedge clk_sys);
        chk(32'(pin_out), 32'(masks[i][s]));
        ev = '0;
      end
    end
    $display("interrupt source test done");
    do_reset();
    wr(`GIS_OFS_PINCTL, 8'h64);
    k = rise_cnt;
    ev = 7'h40;
    for (n = 0; pin_out !== 1'b1 && n < 10; n++) @(negedge clk_sys);
    for (n = 0; pin_out === 1'b1 && n < 60000; n++) @(negedge clk_sys);
    chk(32'(n), 32'(`GIS_PULSE_CYC));
    for (n = 0; pin_out !== 1'b1 && n < 1000; n++) @(negedge clk_sys);
    chk(32'(n), 32'(`GIS_GAP_CYC));
    // host counts a rise at the edge after it appears
    @(negedge clk_sys);
    chk(32'(rise_cnt - k), 32'h2);
    // host acknowledges through the sticky flags
    rd(`GIS_OFS_STICKY, d);
    ev = '0;
    $display("pulse test done");
    finish_test();
  end
endmodule : gis_status_pin_test
